//--- bench/testbench.sv
`timescale 1ns/1ps

module testbench;
	import ple_pkg::*;

	logic        mclk       = 1'h0;
	logic        arst_n     = 1'h0;
	logic [11:0] wb_adr_i   = 12'h000;
	logic [31:0] wb_dat_i   = 32'h0;
	logic [3:0]  wb_sel_i   = 4'h0;
	logic        wb_we_i    = 1'h0;
	logic        wb_cyc_i   = 1'h0;
	logic        wb_stb_i   = 1'h0;
	logic [15:0] ext_in     = 16'h0;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic [7:0]  unl;
	logic [7:0]  lat;
	logic [7:0]  lat_inv;
	logic        scan_done;
	int          num_errors = 0;
	int          checks     = 0;
	int          cycles     = 0;
	int          n;
	logic [31:0] rd;
	logic [31:0] rd2;
	logic [3:0]  x;
	logic        g_exp;
	logic [4:0]  s;
	logic [4:0]  step [7];

	ple_core u_dut (
		.mclk                   (mclk),
		.arst_n                 (arst_n),
		.wb_adr_i               (wb_adr_i),
		.wb_dat_i               (wb_dat_i),
		.wb_sel_i               (wb_sel_i),
		.wb_we_i                (wb_we_i),
		.wb_cyc_i               (wb_cyc_i),
		.wb_stb_i               (wb_stb_i),
		.wb_dat_o               (wb_dat_o),
		.wb_ack_o               (wb_ack_o),
		.ext_in                 (ext_in),
		.logic_equation_unl     (unl),
		.logic_equation_lat     (lat),
		.logic_equation_lat_inv (lat_inv),
		.scan_done              (scan_done)
	);

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	// Classic cycle, held until ack is sampled high
	task automatic wb_xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
			input logic [3:0] sel);
		@(posedge mclk);
		wb_cyc_i <= 1'h1;
		wb_stb_i <= 1'h1;
		wb_we_i  <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= sel;
		do @(posedge mclk); while (wb_ack_o !== 1'h1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'h0;
		wb_stb_i <= 1'h0;
		wb_we_i  <= 1'h0;
	endtask

	task automatic wb_wr(input logic [11:0] a, input logic [31:0] d);
		wb_xfer(1'h1, a, d, 4'hf);
	endtask

	task automatic wb_rd(input logic [11:0] a);
		wb_xfer(1'h0, a, 32'h0, 4'hf);
	endtask

	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] got);
		checks++;
		if (got !== e) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", what, e, got);
		end
	endtask

	// Returns at the edge that samples the end of a scan
	task automatic scans(input int k);
		repeat (k) do @(posedge mclk); while (scan_done !== 1'h1);
	endtask

	// Change lands just after a scan starts, so equation 1 sees it next scan
	task automatic dly(input int d, input logic lvl);
		scans(1);
		ext_in[1] <= lvl;
		n = 0;
		scans(2);
		while (unl[1] !== lvl && n < 40) begin
			n++;
			scans(1);
		end
		chk("delay scans", d, n);
	endtask

	task automatic summarize();
		$display("checks %0d num_errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Clock and hang guard
	initial begin
		forever #50 mclk = ~mclk;
	end

	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			summarize();
		end
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		step = '{5'h13, 5'h01, 5'h1a, 5'h13, 5'h16, 5'h0c, 5'h1f};
		repeat (20) @(posedge mclk);
		arst_n <= 1'h1;
		wb_rd(12'h104);
		chk("ctl reset", 32'h0, rd);
		chk("outputs reset", 32'h00ff0000, {8'h0, lat_inv, lat, unl});
		wb_rd(12'h0f0);
		chk("unmapped", 32'h0, rd);
		$display("reset test done");
		// Every gate over inputs 1..4 with varied inversion
		wb_wr(12'h100, 32'h04030201);
		for (int g = 0; g < 4; g++) begin
			wb_wr(12'h104, 32'(g * 16 + g * 3));
			for (int p = 0; p < 16; p++) begin
				ext_in <= 16'(p) << 1;
				scans(3);
				x = 4'(p) ^ 4'(g * 3);
				g_exp = g[0] ? |x : &x;
				g_exp = g[1] ? ~g_exp : g_exp;
				chk("gate", {31'h0, g_exp}, {31'h0, unl[0]});
			end
		end
		wb_rd(12'h004);
		chk("ext state", 32'h001e, rd);
		$display("gate test done");
		// Rise and fall delays on equation 1
		ext_in <= 16'h0;
		wb_wr(12'h110, 32'h01010101);
		wb_wr(12'h114, 32'h00000010);
		wb_wr(12'h118, 32'h00020003);
		scans(4);
		dly(3, 1'h1);
		dly(2, 1'h0);
		wb_wr(12'h118, 32'h0);
		dly(0, 1'h1);
		dly(0, 1'h0);
		$display("delay test done");
		// Latch with selectable, invertible reset on equation 2
		wb_wr(12'h120, 32'h02020202);
		for (int i = 0; i < 7; i++) begin
			s = step[i];
			wb_wr(12'h124, 32'h0310 | (32'(s[2]) << 6));
			ext_in[3:2] <= {s[3], s[4]};
			scans(3);
			chk("latch", {29'h0, ~s[0], s[0], s[1]}, {29'h0, lat_inv[2], lat[2], unl[2]});
			wb_rd(12'h12c);
			chk("status", {29'h0, ~s[0], s[0], s[1]}, {29'h0, rd[2:0]});
		end
		$display("latch test done");
		// Chain 6 to 7 ascending, 7 back to 5 descending
		wb_wr(12'h160, 32'h05050505);
		wb_wr(12'h164, 32'h00000010);
		wb_wr(12'h170, 32'h16161616);
		wb_wr(12'h174, 32'h00000010);
		wb_wr(12'h150, 32'h17171717);
		wb_wr(12'h154, 32'h00000010);
		scans(3);
		ext_in[5] <= 1'h1;
		scans(1);
		chk("ascending", 32'h6, {29'h0, unl[7:5]});
		scans(1);
		chk("descending", 32'h7, {29'h0, unl[7:5]});
		scans(1);
		wb_rd(12'h000);
		rd2 = rd;
		scans(3);
		wb_rd(12'h000);
		chk("scan count", rd2 + 32'h3, rd);
		// Single byte lane write
		wb_xfer(1'h1, 12'h178, 32'h1234ab56, 4'h2);
		wb_rd(12'h178);
		chk("byte lane", 32'h0000ab00, rd);
		$display("cascade test done");
		summarize();
	end
endmodule // testbench

//--- core/ple_consts.svh
`ifndef PLE_CONSTS_SVH
`define PLE_CONSTS_SVH

// ----------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------
`define PLE_SCAN_CNT_OFS   12'h000
`define PLE_EXT_STATE_OFS  12'h004
`define PLE_EQ_REGION      4'h1
`define PLE_EQ_W_SEL       2'h0
`define PLE_EQ_W_CTL       2'h1
`define PLE_EQ_W_DLY       2'h2
`define PLE_EQ_W_STAT      2'h3

// ----------------------------------------------------------------
// Field masks, status bit positions, reset values
// ----------------------------------------------------------------
`define PLE_SEL_MASK       32'h3f3f3f3f
`define PLE_CTL_MASK       32'h00003f7f
`define PLE_DLY_MASK       32'hffffffff
`define PLE_ST_UNL         0
`define PLE_ST_LAT         1
`define PLE_ST_LAT_INV     2
`define PLE_ST_GATE        3
`define PLE_ST_CNT_LSB     16
`define PLE_CFG_RST        96'h0
`define PLE_CNT_RST        16'h0000

`endif

//--- core/ple_core.sv
// Functional notes
// - Each equation takes four inputs, each picked by a selector from the signal list.
// - Each of the four inputs has its own invert option ahead of the gate.
// - The gate result passes an on-delay for rising and an off-delay for falling edges.
// - Each equation drives an unlatched output and a latched output that holds once set.
// - The complement of the latched output is a further output.
// - The latch is cleared by a selectable reset signal that may be inverted.
// - When set and reset meet in one evaluation the reset wins.
// - Equations are evaluated from the first to the last and the scan repeats forever.
// - Every equation output can be selected as an input of any equation.
// - A lower equation feeding a higher one takes effect within the same scan.
// - A higher equation feeding a lower one takes effect one scan later.
`timescale 1ns/1ps
`include "ple_consts.svh"

module ple_core #(
	parameter int NUM_EQ  = 8,
	parameter int NUM_EXT = 16
) (
	input  wire logic                mclk,
	input  wire logic                arst_n,
	input  wire logic [11:0]         wb_adr_i,
	input  wire logic [31:0]         wb_dat_i,
	input  wire logic [3:0]          wb_sel_i,
	input  wire logic                wb_we_i,
	input  wire logic                wb_cyc_i,
	input  wire logic                wb_stb_i,
	output logic      [31:0]         wb_dat_o,
	output logic                     wb_ack_o,
	input  wire logic [NUM_EXT-1:0]  ext_in,
	output logic      [NUM_EQ-1:0]   logic_equation_unl,
	output logic      [NUM_EQ-1:0]   logic_equation_lat,
	output logic      [NUM_EQ-1:0]   logic_equation_lat_inv,
	output logic                     scan_done
);
	import ple_pkg::*;

	localparam int IW   = (NUM_EQ > 1) ? $clog2(NUM_EQ) : 1;
	localparam int SRCW = NUM_EXT + 3 * NUM_EQ;

	// Byte-lane views of the masks, so a lane never carries reserved bits
	localparam logic [31:0] SEL_MASK = `PLE_SEL_MASK;
	localparam logic [31:0] CTL_MASK = `PLE_CTL_MASK;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic [NUM_EXT-1:0]  ext_s1;
	logic [NUM_EXT-1:0]  ext_s2;
	logic [NUM_EXT-1:0]  ext_s3;
	logic [NUM_EXT-1:0]  ext_f;
	ple_cfg_t            cfg      [NUM_EQ];
	logic [15:0]         cnt      [NUM_EQ];
	logic [NUM_EQ-1:0]   gate_q;
	logic [IW-1:0]       ptr;
	logic [31:0]         scan_cnt;
	logic [SRCW-1:0]     src_all;
	logic [63:0]         src_pad;
	ple_cfg_t            cur;
	logic [3:0]          cond;
	logic                gate_res;
	logic                rst_cond;
	logic [15:0]         dly;
	logic                next_unl;
	logic                next_lat;
	logic [15:0]         next_cnt;
	logic                wb_req;
	logic                wb_wr_take;
	logic [IW-1:0]       bus_eq;
	logic                bus_eq_hit;
	logic [31:0]         next_rdata;

	// ------------------------------------------------------------
	// Pin inputs
	// ------------------------------------------------------------

	// Three stages; a level is taken once stages two and three agree
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ext_s1 <= '0;
			ext_s2 <= '0;
			ext_s3 <= '0;
			ext_f  <= '0;
		end else begin
			ext_s1 <= ext_in;
			ext_s2 <= ext_s1;
			ext_s3 <= ext_s2;
			ext_f  <= (ext_s2 & ext_s3) | (ext_f & (ext_s2 ^ ext_s3));
		end
	end

	// ------------------------------------------------------------
	// Source list and gate of the equation under evaluation
	// ------------------------------------------------------------

	// Outputs are read straight from the output flops: an equation
	// already visited this scan shows its new value, a later one its
	// value from the previous scan
	assign src_all = {logic_equation_lat_inv, logic_equation_lat,
	                  logic_equation_unl, ext_f};
	assign src_pad = 64'(src_all);
	assign cur     = cfg[ptr];

	// Input selection and per-input inversion
	genvar k;
	generate
		for (k = 0; k < 4; k++) begin : g_in
			assign cond[k] = src_pad[cur.sel[k][5:0]] ^ cur.inv[k];
		end
	endgenerate

	// Operator over all four conditioned inputs
	always_comb begin
		unique case (cur.gate)
			PLE_GATE_AND:  gate_res = &cond;
			PLE_GATE_OR:   gate_res = |cond;
			PLE_GATE_NAND: gate_res = ~&cond;
			PLE_GATE_NOR:  gate_res = ~|cond;
		endcase
	end

	// Timer stage, then reset-dominant latch on the delayed result
	always_comb begin
		rst_cond = src_pad[cur.rst_sel] ^ cur.rst_inv;
		dly      = gate_res ? cur.rise_delay_time : cur.fall_delay_time;
		next_unl = logic_equation_unl[ptr];
		next_cnt = `PLE_CNT_RST;
		if (gate_res != logic_equation_unl[ptr]) begin
			if (cnt[ptr] >= dly) begin
				next_unl = gate_res;
			end else begin
				next_cnt = cnt[ptr] + 16'h0001;
			end
		end
		next_lat = rst_cond ? 1'b0 : (logic_equation_lat[ptr] | next_unl);
	end

	// ------------------------------------------------------------
	// Sequential scan, one equation per clock
	// ------------------------------------------------------------

	// Scan pointer and completed-scan count; never stops
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ptr       <= '0;
			scan_cnt  <= '0;
			scan_done <= 1'b0;
		end else if (ptr == IW'(NUM_EQ - 1)) begin
			ptr       <= '0;
			scan_cnt  <= scan_cnt + 32'h1;
			scan_done <= 1'b1;
		end else begin
			ptr       <= ptr + IW'(1);
			scan_done <= 1'b0;
		end
	end

	// Equation outputs and timers; only the visited entry changes
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			logic_equation_unl     <= '0;
			logic_equation_lat     <= '0;
			logic_equation_lat_inv <= '1;
			gate_q                 <= '0;
			for (int i = 0; i < NUM_EQ; i++) begin
				cnt[i] <= `PLE_CNT_RST;
			end
		end else begin
			logic_equation_unl[ptr]     <= next_unl;
			logic_equation_lat[ptr]     <= next_lat;
			logic_equation_lat_inv[ptr] <= ~next_lat;
			gate_q[ptr]                 <= gate_res;
			cnt[ptr]                    <= next_cnt;
		end
	end

	// ------------------------------------------------------------
	// Wishbone slave, answers one clock after the request
	// ------------------------------------------------------------
	assign wb_req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wb_wr_take = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o; // Master still holds data here
	assign bus_eq     = wb_adr_i[IW+3:4];
	assign bus_eq_hit = (wb_adr_i[11:8] == `PLE_EQ_REGION) &&
	                    ({28'h0, wb_adr_i[7:4]} < NUM_EQ);

	// Read mux; unmapped addresses read zero
	always_comb begin
		next_rdata = 32'h0;
		if (bus_eq_hit) begin
			unique case (wb_adr_i[3:2])
				`PLE_EQ_W_SEL: next_rdata = cfg[bus_eq][31:0] & `PLE_SEL_MASK;
				`PLE_EQ_W_CTL: next_rdata = cfg[bus_eq][63:32] & `PLE_CTL_MASK;
				`PLE_EQ_W_DLY: next_rdata = cfg[bus_eq][95:64] & `PLE_DLY_MASK;
				`PLE_EQ_W_STAT: begin
					next_rdata[`PLE_ST_UNL]     = logic_equation_unl[bus_eq];
					next_rdata[`PLE_ST_LAT]     = logic_equation_lat[bus_eq];
					next_rdata[`PLE_ST_LAT_INV] = logic_equation_lat_inv[bus_eq];
					next_rdata[`PLE_ST_GATE]    = gate_q[bus_eq];
					next_rdata[31:`PLE_ST_CNT_LSB] = cnt[bus_eq];
				end
			endcase
		end else if (wb_adr_i == `PLE_SCAN_CNT_OFS) begin
			next_rdata = scan_cnt;
		end else if (wb_adr_i == `PLE_EXT_STATE_OFS) begin
			next_rdata = 32'(ext_f);
		end
	end

	// Ack and read data
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= wb_req;
			if (wb_req && !wb_we_i) begin
				wb_dat_o <= next_rdata;
			end
		end
	end

	// Settings writes land at the edge that samples ack, with byte lanes;
	// reserved bits stored as zero
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < NUM_EQ; i++) begin
				cfg[i] <= `PLE_CFG_RST;
			end
		end else if (wb_wr_take && bus_eq_hit &&
		             wb_adr_i[3:2] != `PLE_EQ_W_STAT) begin
			for (int b = 0; b < 4; b++) begin
				if (wb_sel_i[b]) begin
					unique case (wb_adr_i[3:2])
						`PLE_EQ_W_SEL: cfg[bus_eq][b*8 +: 8] <=
							wb_dat_i[b*8 +: 8] & SEL_MASK[b*8 +: 8];
						`PLE_EQ_W_CTL: cfg[bus_eq][32 + b*8 +: 8] <=
							wb_dat_i[b*8 +: 8] & CTL_MASK[b*8 +: 8];
						default: cfg[bus_eq][64 + b*8 +: 8] <= wb_dat_i[b*8 +: 8];
					endcase
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);

	logic [IW-1:0] ptr_q;
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ptr_q <= '0;
		end else begin
			ptr_q <= ptr;
		end
	end

	sequence last_eq_s;
		ptr == IW'(NUM_EQ - 1);
	endsequence

	sequence scan_wraps_s;
		##1 (ptr == '0) ##1 (ptr == IW'(1 % NUM_EQ));
	endsequence

	scan_wrap_a: assert property (last_eq_s |-> scan_wraps_s)
		else $error("scan pointer did not wrap to first equation");

	scan_count_a: assert property (last_eq_s |=> scan_cnt == $past(scan_cnt) + 32'h1 &&
		scan_done)
		else $error("scan count or done pulse missing at end of scan");

	reset_wins_a: assert property (rst_cond |=> !logic_equation_lat[ptr_q])
		else $error("latch not cleared while reset active");

	latch_set_a: assert property (!rst_cond && next_unl |=>
		logic_equation_lat[ptr_q] ##1 1)
		else $error("latch did not set on active unlatched output");

	latch_inv_a: assert property (logic_equation_lat_inv == ~logic_equation_lat)
		else $error("inverted latch output not complement");

	lat_hold_a: assert property (!rst_cond && logic_equation_lat[ptr] |=>
		logic_equation_lat[ptr_q])
		else $error("latched output dropped without reset");

	zero_delay_a: assert property (dly == 16'h0 && gate_res != logic_equation_unl[ptr]
		|=> logic_equation_unl[ptr_q] == $past(gate_res))
		else $error("zero delay did not pass gate result");

	delay_hold_a: assert property (gate_res != logic_equation_unl[ptr] && cnt[ptr] < dly
		|=> $stable(logic_equation_unl) && cnt[ptr_q] == $past(cnt[ptr]) + 16'h1)
		else $error("output changed before delay expired");

	ack_pulse_a: assert property (wb_req |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus ack not a single cycle after request");

	in_order_a: assert property (ptr != IW'(NUM_EQ - 1) |=> ptr == $past(ptr) + IW'(1))
		else $error("equations not evaluated in ascending order");

endmodule // ple_core

//--- core/ple_pkg.sv
package ple_pkg;

	// ------------------------------------------------------------
	// Gate operators
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		PLE_GATE_AND  = 2'b00,
		PLE_GATE_OR   = 2'b01,
		PLE_GATE_NAND = 2'b10,
		PLE_GATE_NOR  = 2'b11
	} ple_gate_t;

	// ------------------------------------------------------------
	// One equation's settings, three bus words, msb word first
	// ------------------------------------------------------------
	typedef struct packed {
		logic [15:0]      fall_delay_time;
		logic [15:0]      rise_delay_time;
		logic [17:0]      pad_hi;
		logic [5:0]       rst_sel;
		logic             pad_lo;
		logic             rst_inv;
		ple_gate_t        gate;
		logic [3:0]       inv;
		logic [3:0][7:0]  sel;
	} ple_cfg_t;

endpackage
